/* bench/aif_host.sv */
// host model: reset pulse and config gate
`timescale 1ns/1ps
`default_nettype none
module aif_host (
	input wire logic clk_sys_i,
	input wire logic busy_i,
	output var logic rst_o = 1'b1,
	output logic ready_o
);
	int n = 0;
	// reset held 16 cycles, clock already running
	always @(posedge clk_sys_i) begin
		n <= n + 1;
		rst_o <= n < 15;
	end
	// config only after calibration
	assign ready_o = !rst_o && !busy_i;
endmodule // aif_host
`default_nettype wire

/* bench/aif_init_fmt_asserts.sv */
// port assertions for the init and format block
`timescale 1ns/1ps
`default_nettype none
module aif_chk import aif_pkg::*; #(
	parameter int CAL_LEN = CAL_CYCLES,
	parameter int W = SAMPLE_W
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire aif_req_s req_i,
	input wire logic busy_o,
	input wire logic [W-1:0] sample_a_i,
	input wire logic [W-1:0] sample_b_i,
	input wire logic [W-1:0] sample_a_o,
	input wire logic [W-1:0] sample_b_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	int cnt;
	// busy cycle count
	always_ff @(posedge clk_sys_i) cnt <= (rst_i || !busy_o) ? 0 : cnt + 1;
	sequence sw_rst;
		!busy_o && req_i.wr && req_i.addr == REG_CTRL0 && req_i.wdata[0];
	endsequence
	low_bits_a: assert property (!$past(rst_i) |->
		sample_a_o[W-2:0] == $past(sample_a_i[W-2:0])) else $error("a low bits");
	chan_b_bits_a: assert property (!$past(rst_i) |->
		sample_b_o[W-2:0] == $past(sample_b_i[W-2:0])) else $error("b low bits");
	fuse_load_a: assert property ($fell(rst_i) |-> busy_o [*5]) else $error("fuse");
	cal_len_a: assert property ($fell(busy_o) |-> cnt >= CAL_LEN && cnt <= CAL_LEN + 8)
		else $error("cal length");
	sw_reset_a: assert property (sw_rst |=> busy_o [*5]) else $error("sw reset");
endmodule // aif_chk
bind aif_init_fmt aif_chk #(.CAL_LEN(CAL_LEN), .W(W)) aif_chk_i (.clk_sys_i, .rst_i,
	.req_i, .busy_o, .sample_a_i, .sample_b_i, .sample_a_o, .sample_b_o);
`default_nettype wire

/* bench/aif_init_fmt_tb_top.sv */
// random and corner bench for the init and format block
`timescale 1ns/1ps
`default_nettype none
module aif_init_fmt_tb_top;
	import aif_pkg::*;
	logic clk_sys_i = 0, rst_i, busy_o, rdy, rvalid_o;
	aif_req_s req_i = '0;
	logic [7:0] rdata_o, ad[4] = '{REG_FMT_A, REG_FMT_B, REG_CTRL0, 8'h55};
	logic [17:0] sa = '0, sb = '0, oa, ob;
	logic [1:0] fm = '0;
	int num_errors = 0, check_count = 0;
	always #20 clk_sys_i = ~clk_sys_i;
	aif_host aif_host_i (.clk_sys_i, .busy_i(busy_o), .rst_o(rst_i), .ready_o(rdy));
	aif_init_fmt #(.CAL_LEN(20)) aif_init_fmt_i (.clk_sys_i, .rst_i, .ce_i(1'b1), .req_i,
		.rdata_o, .rvalid_o, .busy_o, .sample_a_i(sa), .sample_b_i(sb),
		.sample_a_o(oa), .sample_b_o(ob));
	task automatic cmp(string nm, logic [17:0] e, logic [17:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	// one register cycle, read data taken at answer
	task automatic acc(bit w, logic [7:0] a, logic [7:0] d, output logic [7:0] q);
		@(posedge clk_sys_i);
		req_i <= {w, ~w, a, d};
		@(posedge clk_sys_i);
		req_i <= '0;
		#1 q = rdata_o;
	endtask
	task automatic wait_rdy;
		repeat (80) if (rdy !== 1'b1) @(posedge clk_sys_i);
		#1 cmp("ready", 1, rdy);
	endtask
	task automatic chk_clear;
		logic [7:0] q;
		wait_rdy();
		foreach (ad[i]) begin
			acc(0, ad[i], 0, q);
			cmp("reset value", 0, q);
			cmp("read valid", 1, rvalid_o);
		end
	endtask
	function automatic logic [17:0] fx(logic [17:0] s, logic f);
		return s ^ {f, 17'h0};
	endfunction
	task automatic finish_test;
		if (num_errors == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#200us;
		num_errors++;
		finish_test();
	end
	initial begin
		logic [7:0] q;
		void'($urandom(14));
		chk_clear();
		for (int i = 0; i < 8; i++) begin
			acc(1, ad[i%2], {6'h0, i[1], 1'b0}, q);
			fm[i%2] = i[1];
			acc(0, ad[i%2], 0, q);
			cmp("format reg", {6'h0, i[1], 1'b0}, q);
			@(posedge clk_sys_i);
			sa <= i ? 18'($urandom) : 18'h20000;
			sb <= i ? 18'($urandom) : 18'h1ffff;
			@(posedge clk_sys_i);
			#1 cmp("sample a", fx(sa, fm[0]), oa);
			cmp("sample b", fx(sb, fm[1]), ob);
		end
		acc(1, REG_CTRL0, 8'h01, q);
		#1 cmp("busy", 1, busy_o);
		chk_clear();
		finish_test();
	end
endmodule // aif_init_fmt_tb_top
`default_nettype wire

/* core/aif_fmt_conv.sv */
// one channel sample format converter
`timescale 1ns/1ps
`default_nettype none
module aif_fmt_conv import aif_pkg::*; #(
	parameter int W = SAMPLE_W
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic offset_bin_i,
	input wire logic [W-1:0] sample_i,
	output logic [W-1:0] sample_o
);
	// offset binary flips the msb of a two's complement code
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sample_o <= '0;
		end else if (ce_i) begin
			sample_o <= {sample_i[W-1] ^ offset_bin_i, sample_i[W-2:0]};
		end
	end
endmodule // aif_fmt_conv
`default_nettype wire

/* core/aif_init_fmt.sv */
// reset sequencer, register file and output formatting
`timescale 1ns/1ps
`default_nettype none
module aif_init_fmt import aif_pkg::*; #(
	parameter int CAL_LEN = CAL_CYCLES,
	parameter int W = SAMPLE_W
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire aif_req_s req_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	output logic busy_o,
	input wire logic [W-1:0] sample_a_i,
	input wire logic [W-1:0] sample_b_i,
	output logic [W-1:0] sample_a_o,
	output logic [W-1:0] sample_b_o
);
	localparam int CNT_W = $clog2(CAL_LEN + 1);
	aif_state_e state;
	logic [CNT_W-1:0] cnt;
	logic [7:0] channel_a_number_format;
	logic [7:0] channel_b_number_format;
	logic sw_reset;
	logic sw_req;
	logic fuse_load;
	logic ready;
	logic sw_accept;
	logic wr_ok;
	logic wr_fmt_a;
	logic wr_fmt_b;
	logic cal_done;
	logic next_busy;
	logic [7:0] next_rdata;

	// software reset request seen on the bus
	assign sw_req = req_i.wr && req_i.addr == REG_CTRL0 && req_i.wdata[SW_RESET_BIT];

	// defaults are forced while the fuse phase runs
	assign fuse_load = state == AIF_FUSE;

	// configuration is only accepted once calibration is over
	assign ready = state == AIF_READY;

	// a software reset is honoured only from the ready state
	assign sw_accept = sw_req && ready;

	// writes outside the ready state are dropped silently
	assign wr_ok = req_i.wr && ready;

	// per register write strobes
	assign wr_fmt_a = wr_ok && req_i.addr == REG_FMT_A;
	assign wr_fmt_b = wr_ok && req_i.addr == REG_FMT_B;

	// last calibration cycle, busy may drop at this edge
	assign cal_done = state == AIF_CAL && cnt == '0;

	// sequence: fuse load then calibration after any reset
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state <= AIF_IDLE;
			cnt <= '0;
		end else if (ce_i) begin
			case (state)
				AIF_IDLE: begin
					state <= AIF_FUSE;
					cnt <= CNT_W'(FUSE_CYCLES - 1);
				end
				AIF_FUSE: begin
					if (cnt == '0) begin
						state <= AIF_CAL;
						cnt <= CNT_W'(CAL_LEN - 1);
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				AIF_CAL: begin
					if (cnt == '0) begin
						state <= AIF_READY;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				default: begin
					if (sw_reset) begin
						state <= AIF_IDLE;
					end
				end
			endcase
		end
	end

	// software reset bit, cleared by itself once defaults load
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sw_reset <= 1'b0;
		end else if (ce_i) begin
			if (sw_req && state == AIF_READY) begin
				sw_reset <= 1'b1;
			end else if (fuse_load) begin
				sw_reset <= 1'b0;
			end
		end
	end

	// channel a format register, defaults loaded while fuses read
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			channel_a_number_format <= FMT_RESET;
		end else if (ce_i) begin
			if (fuse_load) begin
				channel_a_number_format <= FMT_RESET;
			end else if (wr_fmt_a) begin
				channel_a_number_format <= req_i.wdata;
			end
		end
	end

	// channel b format register, defaults loaded while fuses read
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			channel_b_number_format <= FMT_RESET;
		end else if (ce_i) begin
			if (fuse_load) begin
				channel_b_number_format <= FMT_RESET;
			end else if (wr_fmt_b) begin
				channel_b_number_format <= req_i.wdata;
			end
		end
	end

	// read mux, unmapped addresses return zero
	always_comb begin
		next_rdata = '0;
		if (!req_i.rd) begin
			next_rdata = '0;
		end else if (req_i.addr == REG_CTRL0) begin
			next_rdata = {7'h00, sw_reset};
		end else if (req_i.addr == REG_FMT_A) begin
			next_rdata = channel_a_number_format;
		end else if (req_i.addr == REG_FMT_B) begin
			next_rdata = channel_b_number_format;
		end else begin
			next_rdata = '0;
		end
	end

	// read data and valid, one cycle after the request
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rdata_o <= '0;
			rvalid_o <= 1'b0;
		end else if (ce_i) begin
			rvalid_o <= req_i.rd;
			rdata_o <= next_rdata;
		end
	end

	// busy rises with an accepted software reset, falls after calibration
	always_comb begin
		next_busy = 1'b1;
		if (ready && !sw_reset && !sw_accept) begin
			next_busy = 1'b0;
		end
		if (cal_done) begin
			next_busy = 1'b0;
		end
	end

	// busy flag register, high while reset holds
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			busy_o <= 1'b1;
		end else if (ce_i) begin
			busy_o <= next_busy;
		end
	end

	aif_fmt_conv #(.W(W)) u_conv_a (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.offset_bin_i(channel_a_number_format[FMT_BIT]),
		.sample_i(sample_a_i),
		.sample_o(sample_a_o)
	);

	aif_fmt_conv #(.W(W)) u_conv_b (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.offset_bin_i(channel_b_number_format[FMT_BIT]),
		.sample_i(sample_b_i),
		.sample_o(sample_b_o)
	);
endmodule // aif_init_fmt
`default_nettype wire

/* core/aif_pkg.sv */
// package with register map, format fields and sequencing constants
// How it works
// - channel A samples two's complement when format bit 1 is zero, else offset binary
// - channel B samples two's complement when format bit 1 is zero, else offset binary
// - on reset release, defaults load from fuses, then calibration starts
// - calibration lasts about 200000 sampling clock cycles
// - writing one to bit 0 of control register zero when ready reloads format defaults and reruns fuse load and calibration; the bit self-clears during fuse load
package aif_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] REG_CTRL0 = 8'h00;
	localparam logic [7:0] REG_FMT_A = 8'h8f;
	localparam logic [7:0] REG_FMT_B = 8'h92;
	localparam logic [7:0] FMT_RESET = 8'h00;
	localparam int FMT_BIT = 1;
	localparam int SW_RESET_BIT = 0;
	localparam int CAL_CYCLES = 200000;
	localparam int FUSE_CYCLES = 4;
	localparam int SAMPLE_W = 18;

	typedef enum logic [1:0] {
		AIF_IDLE,
		AIF_FUSE,
		AIF_CAL,
		AIF_READY
	} aif_state_e;

	// register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} aif_req_s;
endpackage
